// *** src/sep_pkg.sv ***
package sep_pkg;
  // ***************************************************************
  // instruction format
  // ***************************************************************
  localparam int ADDR_W_DEF   = 6;
  localparam int DATA_W       = 16;
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_DIS  = 2'h0;
  localparam logic [1:0] SUB_WRITE_EVERY_REGISTER_CMD = 2'h1;
  localparam logic [1:0] SUB_ERASE_EVERY_REGISTER_CMD = 2'h2;
  localparam logic [1:0] SUB_EN   = 2'h3;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_NS       = 10;
  localparam int WRITE_MS     = 15;
  localparam int WRITE_CYCLES = WRITE_MS * 1000000 / CLK_NS;
  localparam int FIFO_DEPTH   = 8;
  typedef enum logic [2:0] {
    SEP_IDLE, SEP_OPC, SEP_ADDR, SEP_DATA, SEP_READ, SEP_WAIT, SEP_PROG, SEP_DONE
  } sep_state_t;
endpackage

// *** src/sep_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module sep_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clk_en) begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/sep_core.sv ***
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RL1] instruction opens with a one start bit, then opcode, then address bits
// [RL2] opcode 10 read, 01 write, 11 erase; address six or eight bits
// [RL3] opcode 00 uses top address bits: enable, erase all, write all, disable
// [RL4] read loads register, sends a zero dummy bit then sixteen data bits
// [RL5] read data on the serial output changes only after a rising serial clock edge
// [RL6] device starts programming-disabled; enable needed before erase or write
// [RL7] programming stays enabled until a disable instruction executes
// [RL8] erase sets register to ones; select falling edge starts programming
// [RL9] select high during programming shows status: zero busy, one ready
// [RL10] write takes sixteen data bits; select fall starts the write
// [RL11] erase all sets every register to ones
// [RL12] write all stores the pattern into every register
// [RL13] disable blocks erase and write; reads always work
// [RL14] host keeps select low a minimum time between instructions
// [RL15] on larger parts, write needs unprotected address; write all needs clear protect
// [RL16] serial output released while select is low
// [RL17] programming is a bounded busy period; instructions ignored meanwhile
module sep_core
  import sep_pkg::*;
#(
  parameter int ADDR_W      = ADDR_W_DEF,
  parameter int PROG_CYCLES = WRITE_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              chip_select,
  input  wire logic              serial_clock_in,
  input  wire logic              serial_data_in,
  output logic                   serial_data_out,
  output logic                   serial_data_out_oe,
  input  wire logic [ADDR_W-1:0] protect_addr,
  input  wire logic              protect_on,
  output logic                   prog_busy
);
  import sep_pkg::*;
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int AC = $clog2(ADDR_W + DATA_W + 1);
  localparam int NREG = 1 << ADDR_W;

  // ***************************************************************
  // pin synchronisers and edge detection
  // ***************************************************************
  logic [2:0] cs_sync;
  logic [2:0] sk_sync;
  logic [1:0] di_sync;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cs_sync <= 3'h0;
      sk_sync <= 3'h0;
      di_sync <= 2'h0;
    end else if (clk_en) begin
      cs_sync <= {cs_sync[1:0], chip_select};
      sk_sync <= {sk_sync[1:0], serial_clock_in};
      di_sync <= {di_sync[0], serial_data_in};
    end
  end
  logic cs;
  logic cs_fall;
  logic sk_rise;
  logic di;
  assign cs      = cs_sync[1];
  assign cs_fall = cs_sync[2] && !cs_sync[1];
  assign sk_rise = sk_sync[1] && !sk_sync[2];
  assign di      = di_sync[1];

  // ***************************************************************
  // write buffer: programmed words queue here before reaching the array
  // ***************************************************************
  logic [ADDR_W+DATA_W:0] wq_in;
  logic [ADDR_W+DATA_W:0] wq_out;
  logic                   wq_in_valid;
  logic                   wq_in_ready;
  logic                   wq_out_valid;
  logic                   wq_out_ready;
  sep_fifo #(.WIDTH(ADDR_W + DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (wq_in_valid),
    .in_ready  (wq_in_ready),
    .in_data   (wq_in),
    .out_valid (wq_out_valid),
    .out_ready (wq_out_ready),
    .out_data  (wq_out)
  );

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    sep_state_t         st;
    logic [1:0]         op;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
    logic [DATA_W:0]    shout;
    logic [AC-1:0]      cnt;
    logic [CW-1:0]      timer;
    logic               prog_en;
    logic               all;
    logic [ADDR_W:0]    fill;
    logic               dout;
  } sep_reg_t;
  sep_reg_t r;
  sep_reg_t next_r;
  logic [DATA_W-1:0] mem [NREG];

  function automatic logic may_write(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                                     input logic en, input logic pon, input logic [ADDR_W-1:0] pa);
    logic ok;
    ok = en; // RL13
    if (op == OP_WRITE && pon && a >= pa) begin
      ok = 1'b0; // RL15
    end
    if (op == OP_EXT && a[ADDR_W-1 -: 2] == SUB_WRITE_EVERY_REGISTER_CMD && pon) begin
      ok = 1'b0; // RL15
    end
    return ok;
  endfunction

  logic fill_done;
  assign fill_done = r.fill[ADDR_W];
  assign wq_out_ready = 1'b1;

  always_comb begin
    next_r = r;
    wq_in_valid = 1'b0;
    wq_in = '0;
    case (r.st)
      SEP_IDLE: begin
        if (cs && sk_rise && di) begin // RL1
          next_r.st  = SEP_OPC;
          next_r.cnt = '0;
        end
      end
      SEP_OPC: begin
        if (!cs) begin
          next_r.st = SEP_IDLE;
        end else if (sk_rise) begin
          next_r.op  = {r.op[0], di};
          next_r.cnt = r.cnt + 1'b1;
          if (r.cnt == AC'(1)) begin
            next_r.st  = SEP_ADDR;
            next_r.cnt = '0;
          end
        end
      end
      SEP_ADDR: begin
        if (!cs) begin
          next_r.st = SEP_IDLE;
        end else if (sk_rise) begin
          next_r.addr = {r.addr[ADDR_W-2:0], di}; // RL2
          next_r.cnt  = r.cnt + 1'b1;
          if (r.cnt == AC'(ADDR_W - 1)) begin
            next_r.cnt = '0;
            if (r.op == OP_READ) begin
              next_r.st    = SEP_READ; // RL4
              // the dummy zero is already on dout, so the shifter leads with the data msb
              next_r.shout = {mem[next_r.addr], 1'b0};
              next_r.dout  = 1'b0;
            end else if (r.op == OP_WRITE ||
                         (r.op == OP_EXT && next_r.addr[ADDR_W-1 -: 2] == SUB_WRITE_EVERY_REGISTER_CMD)) begin
              next_r.st = SEP_DATA; // RL10
            end else if (r.op == OP_EXT) begin
              next_r.st = SEP_IDLE;
              if (next_r.addr[ADDR_W-1 -: 2] == SUB_EN) begin
                next_r.prog_en = 1'b1; // RL7
              end else if (next_r.addr[ADDR_W-1 -: 2] == SUB_DIS) begin
                next_r.prog_en = 1'b0; // RL13
              end else begin
                next_r.st   = SEP_WAIT; // RL11
                next_r.data = ALL_ONES;
              end
            end else begin
              next_r.st   = SEP_WAIT; // RL8
              next_r.data = ALL_ONES;
            end
          end
        end
      end
      SEP_DATA: begin
        if (!cs) begin
          next_r.st = SEP_IDLE;
        end else if (sk_rise) begin
          next_r.data = {r.data[DATA_W-2:0], di};
          next_r.cnt  = r.cnt + 1'b1;
          if (r.cnt == AC'(DATA_W - 1)) begin
            next_r.st = SEP_WAIT;
          end
        end
      end
      SEP_READ: begin
        if (!cs) begin
          next_r.st = SEP_IDLE;
        end else if (sk_rise) begin
          next_r.dout  = r.shout[DATA_W]; // RL5
          next_r.shout = {r.shout[DATA_W-1:0], 1'b0};
        end
      end
      SEP_WAIT: begin
        if (cs_fall) begin // RL8
          if (may_write(r.op, r.addr, r.prog_en, protect_on, protect_addr)) begin // RL6
            next_r.all   = (r.op == OP_EXT);
            next_r.fill  = '0;
            next_r.timer = CW'(PROG_CYCLES);
            next_r.st    = SEP_PROG;
            next_r.dout  = 1'b0;
          end else begin
            next_r.st = SEP_IDLE;
          end
        end else if (cs && sk_rise) begin
          next_r.st = SEP_IDLE; // a serial clock rise with select still high aborts
        end
      end
      SEP_PROG: begin
        // array update runs while the timer counts so status never lies
        if (!fill_done && wq_in_ready) begin
          wq_in_valid = 1'b1;
          wq_in = {1'b1, r.all ? r.fill[ADDR_W-1:0] : r.addr, r.data}; // RL12
          next_r.fill = r.all ? r.fill + 1'b1 : {1'b1, {ADDR_W{1'b0}}};
        end
        if (r.timer != '0) begin
          next_r.timer = r.timer - 1'b1; // RL17
        end else if (fill_done && !wq_out_valid) begin
          next_r.st   = SEP_DONE;
          next_r.dout = 1'b1; // RL9
        end
      end
      SEP_DONE: begin
        if (!cs || sk_rise) begin
          next_r.st = SEP_IDLE;
          if (!cs) begin
            next_r.dout = 1'b1;
          end
        end
      end
      default: next_r.st = SEP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r         <= '0;
      r.st      <= SEP_IDLE;
      r.prog_en <= 1'b0; // RL6
    end else if (clk_en) begin
      r <= next_r;
      if (wq_out_valid) begin
        mem[wq_out[DATA_W +: ADDR_W]] <= wq_out[DATA_W-1:0];
      end
    end
  end

  assign serial_data_out    = r.dout;
  assign serial_data_out_oe = cs && (r.st == SEP_READ || r.st == SEP_PROG || r.st == SEP_DONE); // RL16
  assign prog_busy          = r.st == SEP_PROG;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_out_released: assert property (!cs |-> !serial_data_out_oe) else $error("output driven with select low"); // RL16
  a_dout_on_edge: assert property (clk_en && $changed(r.dout) && r.st != SEP_PROG && $past(r.st) == SEP_READ
                    |-> $past(sk_rise)) else $error("read output moved without clock edge"); // RL5
  a_dummy_zero: assert property (r.st == SEP_READ && $past(r.st) == SEP_ADDR |-> r.dout == 1'b0)
    else $error("dummy bit not zero"); // RL4
  a_busy_low: assert property (r.st == SEP_PROG |-> serial_data_out == 1'b0) else $error("busy not shown as zero"); // RL9
  a_ready_high: assert property (r.st == SEP_DONE |-> serial_data_out == 1'b1) else $error("ready not shown as one"); // RL9
  a_disabled_block: assert property (r.st == SEP_WAIT && cs_fall && !r.prog_en |=> r.st == SEP_IDLE)
    else $error("program started while disabled"); // RL13
  a_start_on_fall: assert property (clk_en && r.st == SEP_PROG && $past(r.st) != SEP_PROG |-> $past(cs_fall))
    else $error("program started without select fall"); // RL8
  a_busy_ignore: assert property (r.st == SEP_PROG && r.timer != '0 |=> r.st == SEP_PROG)
    else $error("busy period cut short"); // RL17
  a_en_holds: assert property (clk_en && r.prog_en && !next_r.prog_en |-> r.st == SEP_ADDR && r.op == OP_EXT)
    else $error("enable lost without disable"); // RL7
  c_read: cover property (r.st == SEP_READ ##1 r.st == SEP_IDLE);
  c_prog: cover property (r.st == SEP_PROG ##1 r.st == SEP_DONE);
  c_enable: cover property (!r.prog_en ##1 r.prog_en);
endmodule
`default_nettype wire

// *** verif/sep_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// host side of the serial command port
// ***************************************************************
module sep_host_model (
  input  wire logic sys_clk,
  output logic      chip_select,
  output logic      serial_clock_in,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe
);
  logic do_wire;
  assign do_wire = serial_data_out_oe ? serial_data_out : 1'bz;
  initial begin
    chip_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_data_in = 1'b0;
  end
  // half of an 80 ns link period
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask
  // the link clock stands low outside frames
  task automatic shift(input logic [26:0] bits, input int n);
    chip_select = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = bits[i];
      half();
      serial_clock_in = 1'b1;
      half();
      serial_clock_in = 1'b0;
    end
  endtask
  // select drops before any further rise; the data line flips so a stale bit cannot pass
  task automatic idle();
    chip_select = 1'b0;
    serial_data_in = ~serial_data_in;
    repeat (30) @(negedge sys_clk);
  endtask
  task automatic read(input logic [26:0] cmd, input int n, output logic [16:0] got, output logic steady);
    logic a;
    shift(cmd, n);
    steady = 1'b1;
    for (int i = 16; i >= 0; i--) begin
      repeat (3) @(negedge sys_clk);
      a = do_wire;
      @(negedge sys_clk);
      got[i] = do_wire;
      steady = steady & (a === got[i]);
      serial_clock_in = 1'b1;
      half();
      serial_clock_in = 1'b0;
    end
    idle();
  endtask
  // status is looked at once early, then polled under a bound
  task automatic program_cmd(input logic [26:0] cmd, input int n, output logic first, output logic ready);
    shift(cmd, n);
    idle();
    chip_select = 1'b1;
    repeat (8) @(negedge sys_clk);
    first = do_wire;
    ready = do_wire;
    for (int k = 0; k < 400 && ready !== 1'b1; k++) begin
      @(negedge sys_clk);
      ready = do_wire;
    end
    idle();
  endtask
endmodule
`default_nettype wire

// *** verif/tb_sep_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_sep_core;
  import sep_pkg::*;
  logic       sys_clk;
  logic       rst_n;
  logic       chip_select;
  logic       serial_clock_in;
  logic       serial_data_in;
  logic       dout;
  logic       dout_oe;
  logic       busy;
  logic       prot_on;
  logic [5:0] prot_addr;
  int         err_total = 0;
  int         samples_checked = 0;
  int         busy_cycles = 0;
  // counts clocks with the busy flag up, so each program step can judge its busy period
  always @(posedge sys_clk) begin
    if (busy === 1'b1) begin
      busy_cycles++;
    end
  end
  sep_core #(.ADDR_W(6), .PROG_CYCLES(50)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .serial_data_out(dout),
    .serial_data_out_oe(dout_oe), .protect_addr(prot_addr), .protect_on(prot_on), .prog_busy(busy));
  sep_host_model host (
    .sys_clk(sys_clk), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in), .serial_data_out(dout), .serial_data_out_oe(dout_oe));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [26:0] ins(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    return {2'h0, 1'b1, op, a, d};
  endfunction
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    logic [16:0] got;
    logic        st;
    host.read(ins(OP_READ, a, 16'h0) >> 16, 9, got, st);
    check("read word", got, {1'b0, exp});
    check("output steady", {16'h0, st}, 17'h1);
  endtask
  task automatic pg(input logic [26:0] c, input int n, input logic ok);
    logic f;
    logic r;
    int   b0;
    b0 = busy_cycles;
    host.program_cmd(c, n, f, r);
    check("busy period", {16'h0, (busy_cycles - b0) > 50}, {16'h0, ok});
    check("status busy", {16'h0, f}, {16'h0, ok ? 1'b0 : 1'bz});
    check("status ready", {16'h0, r}, {16'h0, ok ? 1'b1 : 1'bz});
  endtask
  task automatic ext(input logic [1:0] sub);
    host.shift(ins(OP_EXT, {sub, 4'h0}, 16'h0) >> 16, 9);
    host.idle();
  endtask
  task automatic s_power_up();
    check("idle enable", {16'h0, dout_oe}, 17'h0);
    check("idle busy", {16'h0, busy}, 17'h0);
    pg(ins(OP_WRITE, 6'h03, 16'h1234), 25, 1'b0);
  endtask
  task automatic s_write_erase();
    ext(SUB_EN);
    pg(ins(OP_WRITE, 6'h03, 16'hA5C3), 25, 1'b1);
    pg(ins(OP_WRITE, 6'h3F, 16'h8001), 25, 1'b1);
    rd(6'h03, 16'hA5C3);
    pg(ins(OP_ERASE, 6'h03, 16'h0) >> 16, 9, 1'b1);
    rd(6'h03, 16'hFFFF);
    rd(6'h3F, 16'h8001);
  endtask
  task automatic s_all();
    pg(ins(OP_EXT, {SUB_WRITE_EVERY_REGISTER_CMD, 4'h0}, 16'h5A0F), 25, 1'b1);
    rd(6'h00, 16'h5A0F);
    rd(6'h3F, 16'h5A0F);
    pg(ins(OP_EXT, {SUB_ERASE_EVERY_REGISTER_CMD, 4'h0}, 16'h0) >> 16, 9, 1'b1);
    rd(6'h15, 16'hFFFF);
  endtask
  task automatic s_disable();
    ext(SUB_DIS);
    pg(ins(OP_WRITE, 6'h00, 16'h0000), 25, 1'b0);
    rd(6'h00, 16'hFFFF);
  endtask
  task automatic s_protect();
    ext(SUB_EN);
    prot_addr = 6'h20;
    prot_on = 1'b1;
    pg(ins(OP_WRITE, 6'h28, 16'h0000), 25, 1'b0);
    pg(ins(OP_WRITE, 6'h05, 16'h1234), 25, 1'b1);
    pg(ins(OP_EXT, {SUB_WRITE_EVERY_REGISTER_CMD, 4'h0}, 16'h0000), 25, 1'b0);
    rd(6'h28, 16'hFFFF);
    rd(6'h05, 16'h1234);
  endtask
  // the full sequence needs about 6,600 cycles
  initial begin
    #400us;
    err_total++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    prot_on = 1'b0;
    prot_addr = 6'h00;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    s_power_up();
    s_write_erase();
    s_all();
    s_disable();
    s_protect();
    report_and_stop();
  end
endmodule
`default_nettype wire
